// [opc_pkg.sv]
package opc_pkg;

    // apb register map (byte addresses)
    localparam logic [7:0]  OPC_REG_PLL_CFG    = 8'h00;
    localparam logic [7:0]  OPC_REG_STATUS     = 8'h04;
    localparam logic [7:0]  OPC_REG_TIMER      = 8'h08;
    localparam logic [7:0]  OPC_REG_RTC        = 8'h0C;
    localparam logic [7:0]  OPC_REG_REF_DIV    = 8'h10;

    // pll config field layout
    localparam int OPC_R_LSB  = 0;
    localparam int OPC_R_W    = 6;
    localparam int OPC_F_LSB  = 8;
    localparam int OPC_F_W    = 12;
    localparam int OPC_OD_LSB = 24;
    localparam int OPC_OD_W   = 3;

    // status field positions
    localparam int OPC_ST_BOOT_BIT   = 0;
    localparam int OPC_ST_SRC_BIT    = 1;
    localparam int OPC_ST_BAND_LSB   = 2;
    localparam int OPC_ST_SWCFG_BIT  = 4;

    // strap defaults per band {high,low}
    localparam logic [2:0]  OPC_OD_B00 = 3'h1;
    localparam logic [11:0] OPC_F_B00  = 12'h07A;
    localparam logic [2:0]  OPC_OD_B11 = 3'h2;
    localparam logic [11:0] OPC_F_B11  = 12'h077;
    localparam logic [2:0]  OPC_OD_B10 = 3'h2;
    localparam logic [11:0] OPC_F_B10  = 12'h031;
    localparam logic [2:0]  OPC_OD_B01 = 3'h2;
    localparam logic [11:0] OPC_F_B01  = 12'h017;
    localparam logic [5:0]  OPC_R_DEF  = 6'h00;

    // timing
    localparam int OPC_SYS_CLK_HZ      = 25000000;
    localparam int OPC_BOOT_WAIT_CLKS  = 750000;
    localparam int OPC_SILICON_OSC_HZ  = 20000000;
    localparam int OPC_RTC_OSC_HZ      = 31250;
    localparam int OPC_REF_CLK_HZ      = 100000000;
    localparam int OPC_TIMER_TICK_NS   = 10;
    localparam int OPC_REF_DIV_DEF     = 4;
    localparam int OPC_RTC_DIV_CLKS    = OPC_SYS_CLK_HZ / OPC_RTC_OSC_HZ;

    typedef enum logic [2:0] {
        OPC_ST_RESET = 3'b001,
        OPC_ST_WAIT  = 3'b010,
        OPC_ST_RUN   = 3'b100
    } opc_state_t;

    // tile ratio numerator/denominator: (f+1) / (2*(r+1)*(od+1))
    function automatic logic [31:0] opc_ratio_den(input logic [5:0] r, input logic [2:0] od);
        opc_ratio_den = 32'(2 * (32'(r) + 1) * (32'(od) + 1));
    endfunction : opc_ratio_den

endpackage : opc_pkg

// [opc_pll_if.sv]
`timescale 1ns/1ps
interface opc_pll_if;
    logic [2:0]  post_divider;
    logic [11:0] mult;
    logic [5:0]  in_div;
    logic        clk_en;
    logic [31:0] ratio_num;
    logic [31:0] ratio_den;
    modport ctrl (output post_divider, output mult, output in_div, input clk_en,
                  input ratio_num, input ratio_den);
    modport pll  (input post_divider, input mult, input in_div, output clk_en,
                  output ratio_num, output ratio_den);
endinterface : opc_pll_if

// [opc_pll_model.sv]
`timescale 1ns/1ps
// fractional rate generator standing in for the analogue pll:
// clk_en pulses at osc*(f+1)/2/(r+1)/(od+1) relative to the input clock,
// saturated to one pulse per cycle since one clock is all we have
module opc_pll_model
    import opc_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    opc_pll_if.pll    pll
);
    logic [31:0] acc_q;
    logic [31:0] num;
    logic [31:0] den;
    logic [32:0] sum;

    assign num           = 32'(pll.mult) + 32'd1;
    assign den           = opc_ratio_den(pll.in_div, pll.post_divider);
    assign pll.ratio_num = num;
    assign pll.ratio_den = den;
    assign sum           = {1'b0, acc_q} + {1'b0, num};

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q      <= 32'h0000_0000;
            pll.clk_en <= 1'b0;
        end else if (sum >= {1'b0, den}) begin
            acc_q      <= (sum - {1'b0, den}) >= {1'b0, den} ? 32'h0000_0000
                          : 32'(sum - {1'b0, den});
            pll.clk_en <= 1'b1;
        end else begin
            acc_q      <= sum[31:0];
            pll.clk_en <= 1'b0;
        end
    end
endmodule : opc_pll_model

// [opc_clock_ctrl.sv]
`timescale 1ns/1ps
// What this block does
// - strap picks external or 20 MHz internal
// - band straps set default pll settings
// - tile rate follows pll ratio formula
// - software rewrites pll settings at run time
// - pll clocks switch, tile, reference
// - analogue node runs at oscillator rate
// - 100 MHz reference, 32-bit 10 ns timer
// - 31,250 Hz clock drives real-time counter
// - wait 750,000 clocks then pulls, boot
module opc_clock_ctrl
    import opc_pkg::*;
#(
    parameter int BOOT_WAIT_CLKS = OPC_BOOT_WAIT_CLKS,
    parameter int RTC_DIV_CLKS   = OPC_RTC_DIV_CLKS
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        oscillator_source_select_n_i,
    input  wire logic        band_strap_low_i,
    input  wire logic        band_strap_high_i,
    input  wire logic        low_power_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             use_internal_osc_o,
    output logic             analog_clk_en_o,
    output logic             tile_clk_en_o,
    output logic             switch_clk_en_o,
    output logic             ref_clk_en_o,
    output logic             rtc_clk_en_o,
    output logic             pull_enable_o,
    output logic             boot_start_o
);
    opc_pll_if   pll_bus ();
    opc_state_t  state_q;
    logic [31:0] wait_cnt_q;
    logic        strap_seen_q;
    logic        src_int_q;
    logic [1:0]  band_q;
    logic [2:0]  od_q;
    logic [11:0] f_q;
    logic [5:0]  r_q;
    logic        sw_cfg_q;
    logic [7:0]  ref_div_q;
    logic [7:0]  ref_cnt_q;
    logic [31:0] timer_q;
    logic [31:0] rtc_cnt_q;
    logic [15:0] rtc_div_q;
    logic        rtc_tick;
    logic        acc_wr;
    logic        acc_rd;
    logic        addr_ok;

    ////////////////////////////////////////////////////////////////////////////
    // boot sequencing

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q       <= OPC_ST_RESET;
            wait_cnt_q    <= 32'h0000_0000;
            pull_enable_o <= 1'b0;
            boot_start_o  <= 1'b0;
        end else begin
            boot_start_o <= 1'b0;
            case (state_q)
                OPC_ST_RESET: begin
                    state_q <= OPC_ST_WAIT;
                end
                OPC_ST_WAIT: begin
                    if (wait_cnt_q >= 32'(BOOT_WAIT_CLKS - 1)) begin
                        state_q       <= OPC_ST_RUN;
                        pull_enable_o <= 1'b1;
                        boot_start_o  <= 1'b1;
                    end else begin
                        wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
                    end
                end
                OPC_ST_RUN: begin
                    pull_enable_o <= 1'b1;
                end
                default: begin
                    state_q <= OPC_ST_RESET;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap capture and pll settings

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            strap_seen_q <= 1'b0;
            src_int_q    <= 1'b0;
            band_q       <= 2'b00;
        end else if (!strap_seen_q) begin
            strap_seen_q <= 1'b1;
            src_int_q    <= oscillator_source_select_n_i;
            band_q       <= {band_strap_high_i, band_strap_low_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    // decoder feeds the slave error only; the read mux keeps its own case on paddr_i
    function automatic logic reg_mapped(input logic [7:0] a);
        case (a)
            OPC_REG_PLL_CFG,
            OPC_REG_STATUS,
            OPC_REG_TIMER,
            OPC_REG_RTC,
            OPC_REG_REF_DIV: reg_mapped = 1'b1;
            default:         reg_mapped = 1'b0;
        endcase
    endfunction : reg_mapped

    // access phase only; pready is tied high so every access is one cycle
    assign acc_wr  = psel_i && penable_i && pwrite_i;
    assign acc_rd  = psel_i && penable_i && !pwrite_i;
    assign addr_ok = reg_mapped(paddr_i);

    // software write wins once taken; straps only fill the defaults
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            od_q     <= OPC_OD_B00;
            f_q      <= OPC_F_B00;
            r_q      <= OPC_R_DEF;
            sw_cfg_q <= 1'b0;
        end else if (acc_wr && paddr_i == OPC_REG_PLL_CFG) begin
            od_q     <= pwdata_i[OPC_OD_LSB +: OPC_OD_W];
            f_q      <= pwdata_i[OPC_F_LSB +: OPC_F_W];
            r_q      <= pwdata_i[OPC_R_LSB +: OPC_R_W];
            sw_cfg_q <= 1'b1;
        end else if (!strap_seen_q) begin
            r_q <= OPC_R_DEF;
            case ({band_strap_high_i, band_strap_low_i})
                2'b00: begin
                    od_q <= OPC_OD_B00;
                    f_q  <= OPC_F_B00;
                end
                2'b11: begin
                    od_q <= OPC_OD_B11;
                    f_q  <= OPC_F_B11;
                end
                2'b10: begin
                    od_q <= OPC_OD_B10;
                    f_q  <= OPC_F_B10;
                end
                default: begin
                    od_q <= OPC_OD_B01;
                    f_q  <= OPC_F_B01;
                end
            endcase
        end
    end

    assign pll_bus.post_divider = od_q;
    assign pll_bus.mult         = f_q;
    assign pll_bus.in_div       = r_q;

    opc_pll_model u_pll (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pll       (pll_bus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock enables

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tile_clk_en_o   <= 1'b0;
            switch_clk_en_o <= 1'b0;
        end else begin
            tile_clk_en_o   <= pll_bus.clk_en && state_q == OPC_ST_RUN;
            switch_clk_en_o <= pll_bus.clk_en;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            analog_clk_en_o    <= 1'b0;
            use_internal_osc_o <= 1'b0;
        end else begin
            analog_clk_en_o    <= strap_seen_q;
            use_internal_osc_o <= src_int_q;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ref_cnt_q    <= 8'h00;
            ref_clk_en_o <= 1'b0;
        end else begin
            ref_clk_en_o <= 1'b0;
            if (pll_bus.clk_en) begin
                if (ref_cnt_q + 8'h01 >= ref_div_q) begin
                    ref_cnt_q    <= 8'h00;
                    ref_clk_en_o <= 1'b1;
                end else begin
                    ref_cnt_q <= ref_cnt_q + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            timer_q <= 32'h0000_0000;
        end else if (ref_clk_en_o) begin
            timer_q <= timer_q + 32'h0000_0001;
        end
    end

    // low-rate rtc divider, runs in low power
    assign rtc_tick = (rtc_div_q == 16'(RTC_DIV_CLKS - 1));

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rtc_div_q    <= 16'h0000;
            rtc_clk_en_o <= 1'b0;
            rtc_cnt_q    <= 32'h0000_0000;
        end else begin
            rtc_clk_en_o <= rtc_tick;
            rtc_div_q    <= rtc_tick ? 16'h0000 : rtc_div_q + 16'h0001;
            if (rtc_tick) begin
                rtc_cnt_q <= rtc_cnt_q + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ref_div_q <= 8'(OPC_REF_DIV_DEF);
        end else if (acc_wr && paddr_i == OPC_REG_REF_DIV && pwdata_i[7:0] != 8'h00) begin
            ref_div_q <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                OPC_REG_PLL_CFG: prdata_o <= {5'h00, od_q, 4'h0, f_q, 2'h0, r_q};
                OPC_REG_STATUS:  prdata_o <= {27'h000_0000, sw_cfg_q, band_q, src_int_q,
                                              state_q == OPC_ST_RUN};
                OPC_REG_TIMER:   prdata_o <= timer_q;
                OPC_REG_RTC:     prdata_o <= rtc_cnt_q;
                OPC_REG_REF_DIV: prdata_o <= {24'h00_0000, ref_div_q};
                default:         prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;

    // low_power gates nothing; tile side and rtc above both ignore it
    logic unused_lp;
    assign unused_lp = low_power_i & acc_rd;

endmodule : opc_clock_ctrl

// [opc_clock_checker.sv]
`timescale 1ns/1ps
module opc_clock_checker #(
    parameter int BOOT_WAIT_CLKS = 20,
    parameter int RTC_DIV_CLKS   = 4
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       oscillator_source_select_n_i,
    input  wire logic       psel_i,
    input  wire logic       penable_i,
    input  wire logic [7:0] paddr_i,
    input  wire logic       pready_o,
    input  wire logic       pslverr_o,
    input  wire logic       use_internal_osc_o,
    input  wire logic       analog_clk_en_o,
    input  wire logic       tile_clk_en_o,
    input  wire logic       rtc_clk_en_o,
    input  wire logic       pull_enable_o,
    input  wire logic       boot_start_o
);
    // window of a few clocks around the nominal boot wait
    localparam int BOOT_LO = BOOT_WAIT_CLKS - 10;
    localparam int BOOT_HI = BOOT_WAIT_CLKS - 4;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////
    zero_wait_a: assert property (pready_o)
        else $error("pready low");
    bad_addr_a: assert property (psel_i && penable_i && paddr_i > 8'h10 |-> pslverr_o)
        else $error("no slave error on unmapped address");
    boot_wait_a: assert property ($fell(rst_i) |-> !pull_enable_o[*8]
        ##[BOOT_LO:BOOT_HI] (boot_start_o && $rose(pull_enable_o)))
        else $error("boot wait length wrong");
    boot_pulse_a: assert property (boot_start_o |=> !boot_start_o)
        else $error("boot start longer than one cycle");
    pull_hold_a: assert property (pull_enable_o |=> pull_enable_o)
        else $error("pull enable dropped");
    tile_run_a: assert property (tile_clk_en_o |-> pull_enable_o)
        else $error("tile clock before boot");
    analog_rate_a: assert property (pull_enable_o |-> analog_clk_en_o)
        else $error("analogue node not at oscillator rate");
    osc_source_a: assert property (pull_enable_o |->
        use_internal_osc_o == oscillator_source_select_n_i)
        else $error("oscillator source wrong");
    rtc_period_a: assert property (rtc_clk_en_o |=> !rtc_clk_en_o[*3] ##1 rtc_clk_en_o)
        else $error("rtc tick spacing wrong");
endmodule : opc_clock_checker

// [opc_strap_model.sv]
`timescale 1ns/1ps
module opc_strap_model (
    input  wire logic [1:0] band_i,
    input  wire logic       src_i,
    output logic            oscillator_source_select_n_o,
    output logic            band_strap_high_o,
    output logic            band_strap_low_o
);
    assign oscillator_source_select_n_o = src_i;
    assign {band_strap_high_o, band_strap_low_o} = band_i;
endmodule : opc_strap_model

// [test_opc_clock_ctrl.sv]
`timescale 1ns/1ps
module test_opc_clock_ctrl;
    import opc_pkg::*;
    localparam int BOOT_WAIT_CLKS = 20;
    localparam int RTC_DIV_CLKS   = 4;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [1:0]  band = 2'h0;
    logic        src = 1'b0;
    logic        low_power_i = 1'b0;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic        oscillator_source_select_n_i, band_strap_low_i, band_strap_high_i;
    logic        pready_o, pslverr_o, use_internal_osc_o, analog_clk_en_o, tile_clk_en_o;
    logic        switch_clk_en_o, ref_clk_en_o, rtc_clk_en_o, pull_enable_o, boot_start_o;
    int          bad_count = 0;
    int          num_checks = 0;
    int          tile_seen = 0, ref_seen = 0, rtc_seen = 0, switch_seen = 0;
    // band-indexed defaults {high,low}
    logic [2:0]  od_t [4] = '{3'h1, 3'h2, 3'h2, 3'h2};
    logic [11:0] f_t [4] = '{12'd122, 12'd23, 12'd49, 12'd119};

    always #20 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        tile_seen += int'(tile_clk_en_o === 1'b1);
        ref_seen += int'(ref_clk_en_o === 1'b1);
        rtc_seen += int'(rtc_clk_en_o === 1'b1);
        switch_seen += int'(switch_clk_en_o === 1'b1);
    end

    opc_strap_model strap (.band_i(band), .src_i(src),
        .oscillator_source_select_n_o(oscillator_source_select_n_i),
        .band_strap_high_o(band_strap_high_i), .band_strap_low_o(band_strap_low_i));
    opc_clock_ctrl #(.BOOT_WAIT_CLKS(BOOT_WAIT_CLKS), .RTC_DIV_CLKS(RTC_DIV_CLKS)) uut (
        .clk_sys_i, .rst_i, .oscillator_source_select_n_i, .band_strap_low_i,
        .band_strap_high_i, .low_power_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .use_internal_osc_o,
        .analog_clk_en_o, .tile_clk_en_o, .switch_clk_en_o, .ref_clk_en_o,
        .rtc_clk_en_o, .pull_enable_o, .boot_start_o);

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] near(input int a, input int b);
        near = 32'((a >= b - 2) && (a <= b + 2));
    endfunction : near

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        @(posedge clk_sys_i);
        for (int n = 0; n < 16 && pready_o !== 1'b1; n++) @(posedge clk_sys_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : apb

    task automatic boot(input logic [1:0] b, input logic s);
        rst_i <= 1'b1;
        band <= b;
        src <= s;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        for (int n = 0; n < 100 && pull_enable_o !== 1'b1; n++) @(posedge clk_sys_i);
    endtask : boot

    ////////////////////////////////////////////////////////////////////////
    task automatic straps_test;
        logic [31:0] v;
        logic        e;
        for (int b = 0; b < 4; b++) begin
            boot(2'(b), b[0]);
            apb(1'b0, OPC_REG_PLL_CFG, 32'h0, v, e);
            check(v, (32'(od_t[b]) << OPC_OD_LSB) | (32'(f_t[b]) << OPC_F_LSB));
            apb(1'b0, OPC_REG_STATUS, 32'h0, v, e);
            check(v, 32'h1 | (32'(b[0]) << OPC_ST_SRC_BIT) | (32'(b) << OPC_ST_BAND_LSB));
            check(32'(use_internal_osc_o), 32'(b[0]));
        end
        // last boot latched band 3; moving the pins now must change nothing
        band <= 2'h0;
        repeat (5) @(posedge clk_sys_i);
        apb(1'b0, OPC_REG_PLL_CFG, 32'h0, v, e);
        check(v, (32'(od_t[3]) << OPC_OD_LSB) | (32'(f_t[3]) << OPC_F_LSB));
        band <= 2'h3;
    endtask : straps_test

    task automatic ratio_test(input logic [31:0] cfg, input int exp);
        logic [31:0] v, t0, t1;
        logic        e;
        int          a0, r0, c0, s0;
        low_power_i <= 1'b1;
        apb(1'b1, OPC_REG_PLL_CFG, cfg, v, e);
        apb(1'b0, OPC_REG_PLL_CFG, 32'h0, v, e);
        check(v, cfg);
        apb(1'b0, OPC_REG_TIMER, 32'h0, t0, e);
        a0 = tile_seen;
        r0 = ref_seen;
        c0 = rtc_seen;
        s0 = switch_seen;
        repeat (400) @(posedge clk_sys_i);
        apb(1'b0, OPC_REG_TIMER, 32'h0, t1, e);
        check(near(tile_seen - a0, exp), 32'h1);
        check(near(ref_seen - r0, exp / 4), 32'h1);
        check(near(switch_seen - s0, exp), 32'h1);
        check(near(int'(t1 - t0), ref_seen - r0), 32'h1);
        check(near(rtc_seen - c0, 100), 32'h1);
        low_power_i <= 1'b0;
    endtask : ratio_test

    task automatic bus_test;
        logic [31:0] v;
        logic        e;
        apb(1'b0, OPC_REG_REF_DIV, 32'h0, v, e);
        check(v, 32'h0000_0004);
        apb(1'b1, OPC_REG_REF_DIV, 32'h0, v, e);
        apb(1'b1, 8'h14, 32'hFFFF_FFFF, v, e);
        check(32'(e), 32'h1);
        apb(1'b0, 8'h14, 32'h0, v, e);
        check(v, 32'h0);
        apb(1'b0, OPC_REG_REF_DIV, 32'h0, v, e);
        check(v, 32'h0000_0004);
    endtask : bus_test

    task automatic wrap_up;
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    initial begin
        straps_test();
        bus_test();
        ratio_test(32'h0300_0100, 100);
        ratio_test(32'h0000_0101, 200);
        wrap_up();
    end

    initial begin
        #(40 * 20000);
        bad_count++;
        wrap_up();
    end
endmodule : test_opc_clock_ctrl

bind opc_clock_ctrl opc_clock_checker #(.BOOT_WAIT_CLKS(BOOT_WAIT_CLKS),
    .RTC_DIV_CLKS(RTC_DIV_CLKS)) chk (.clk_sys_i, .rst_i, .oscillator_source_select_n_i,
    .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o, .use_internal_osc_o,
    .analog_clk_en_o, .tile_clk_en_o, .rtc_clk_en_o, .pull_enable_o, .boot_start_o);
